// >>> tsa_pkg.sv
package tsa_pkg;

  localparam int NUM_CIRC = 2;
  localparam int NUM_PINS = 5;
  localparam int SLOT_BITS = 8;
  localparam int LIST_DEPTH = 16;
  localparam int MAX_SLOTS = 32;
  localparam int IN_FIFO_DEPTH = 24;
  localparam int REF_CLK_MAX_MHZ = 25;

  // Synchroniser vector layout.
  localparam int SYN_W = 10;
  localparam int SYN_ACLK = 0;
  localparam int SYN_BCLK = 1;
  localparam int SYN_SD = 3;
  localparam int SYN_WS = 8;

  // Bit clock division stages, index is the divider select code.
  localparam logic [15:0][9:0] DIV_TABLE = {
    10'h200, 10'h180, 10'h100, 10'h0C0, 10'h080, 10'h060, 10'h040, 10'h030,
    10'h020, 10'h018, 10'h010, 10'h00C, 10'h008, 10'h006, 10'h004, 10'h002};

  // Time slot list record fields.
  localparam int REC_WS_LO = 27;
  localparam int REC_STORE_LO = 25;
  localparam int REC_BSEL_LO = 22;
  localparam int REC_OUT_EN = 21;
  localparam int REC_PIN_LO = 18;
  localparam int REC_INSEL_LO = 16;
  localparam int REC_LOAD = 15;
  localparam int REC_LAST = 0;

  // Store destinations of a received byte.
  localparam logic [1:0] STORE_NONE = 2'h0;
  localparam logic [1:0] STORE_DWORD = 2'h1;
  localparam logic [1:0] STORE_FB = 2'h2;
  localparam logic [1:0] STORE_BOTH = 2'h3;

  localparam logic [2:0] LAST_BIT = 3'h7;
  localparam logic [2:0] FIRST_BIT = 3'h0;
  localparam logic [1:0] LAST_PLACE = 2'h3;
  localparam logic [4:0] LAST_SLOT = 5'h1F;

endpackage

// >>> tsa_fifo.sv
`timescale 1ns/1ns
`default_nettype none

module tsa_fifo
  import tsa_pkg::*;
#(
  parameter int WIDTH = 32,
  parameter int DEPTH = IN_FIFO_DEPTH
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic clk_en,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);

  localparam int PW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH + 1);
  localparam logic [PW-1:0] PTR_LAST = PW'(DEPTH - 1);
  localparam logic [CW-1:0] CNT_FULL = CW'(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [PW-1:0] wr;
    logic [PW-1:0] rd;
    logic [CW-1:0] cnt;
  } tsa_fifo_s;

  tsa_fifo_s q;
  tsa_fifo_s d;
  logic push;
  logic pop;

  // ----------------------------------------
  // Handshake and storage.
  // ----------------------------------------
  assign in_ready = (q.cnt != CNT_FULL);
  assign out_valid = (q.cnt != '0);
  assign out_data = q.mem[q.rd];

  // Push and pop move their pointers and the fill count.
  always_comb begin
    d = q;
    push = in_valid && in_ready;
    pop = out_valid && out_ready;
    if (push) begin
      d.mem[q.wr] = in_data;
      d.wr = (q.wr == PTR_LAST) ? '0 : q.wr + 1'b1;
    end
    if (pop) begin
      d.rd = (q.rd == PTR_LAST) ? '0 : q.rd + 1'b1;
    end
    if (push && !pop) begin
      d.cnt = q.cnt + 1'b1;
    end else if (pop && !push) begin
      d.cnt = q.cnt - 1'b1;
    end
  end

  // State register.
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      q <= '0;
    end else if (clk_en) begin
      q <= d;
    end
  end

endmodule

`default_nettype wire

// >>> tsa_port.sv
`timescale 1ns/1ns
`default_nettype none

module tsa_port
  import tsa_pkg::*;
(
  input wire logic clk,
  input wire logic reset,
  input wire logic clk_en,
  input wire logic audio_ref_clock,
  input wire logic bit_clock_first_in,
  output logic bit_clock_first_out,
  output logic bit_clock_first_oe_n,
  input wire logic bit_clock_second_in,
  output logic bit_clock_second_out,
  output logic bit_clock_second_oe_n,
  input wire logic [4:0] serial_data_pin_in,
  output logic [4:0] serial_data_pin_out,
  output logic [4:0] serial_data_pin_oe_n,
  input wire logic [4:0] word_select_pin_in,
  output logic [4:0] word_select_pin_out,
  output logic [4:0] word_select_pin_oe_n,
  input wire logic [1:0] circuit_enable,
  input wire logic [1:0] bit_clock_master,
  input wire logic [1:0][3:0] clock_div_sel,
  input wire logic [1:0] ext_sync_mode,
  input wire logic [1:0] ext_sync_early,
  input wire logic [1:0] ws_out_early,
  input wire logic [1:0] little_endian,
  input wire logic [4:0] ws_gen_sel,
  input wire logic [4:0] ws_pin_drive,
  input wire logic list_wr_en,
  input wire logic list_wr_circuit,
  input wire logic [3:0] list_wr_index,
  input wire logic [31:0] list_wr_data,
  input wire logic fb_wr_en,
  input wire logic fb_wr_circuit,
  input wire logic [31:0] fb_wr_data,
  output logic [1:0][31:0] fb_rd_data,
  input wire logic [1:0][31:0] out_word_data,
  input wire logic [1:0] out_word_valid,
  output logic [1:0] out_word_ready,
  output logic [1:0][31:0] in_word_data,
  output logic [1:0] in_word_valid,
  input wire logic [1:0] in_word_ready,
  output logic [1:0][4:0] slot_count,
  output logic [1:0] in_overrun
);

  typedef struct packed {
    logic [SYN_W-1:0] s1;
    logic [SYN_W-1:0] s2;
    logic [SYN_W-1:0] s3;
    logic [SYN_W-1:0] filt;
    logic [1:0][9:0] div_cnt;
    logic [1:0] bclk;
    logic [1:0] sync_lvl;
    logic [1:0][2:0] bitc;
    logic [1:0][4:0] slot;
    logic [1:0][7:0] rx;
    logic [1:0][7:0] tx;
    logic [1:0] tx_bit;
    logic [1:0] tx_act;
    logic [1:0][2:0] tx_pin;
    logic [1:0][31:0] in_buf;
    logic [1:0][1:0] in_ptr;
    logic [1:0][31:0] in_word;
    logic [1:0] in_val;
    logic [1:0] overrun;
    logic [1:0][31:0] fb;
    logic [1:0][1:0] fb_ptr;
    logic [1:0][31:0] out_buf;
    logic [1:0][4:0] ws;
    logic [1:0][LIST_DEPTH-1:0][31:0] time_slot_list;
    logic [4:0] sd_out;
    logic [4:0] sd_oe_n;
    logic [4:0] ws_out;
    logic [4:0] ws_oe_n;
  } tsa_state_s;

  tsa_state_s q;
  tsa_state_s d;
  logic [1:0] fifo_ready;
  logic aclk_rise;
  logic [1:0] rise;
  logic [1:0] fall;

  // ----------------------------------------
  // Next state of both circuits and the pins.
  // ----------------------------------------
  always_comb begin
    logic [31:0] rec;
    logic [31:0] nrec;
    logic [9:0] div;
    logic [9:0] cnt_n;
    logic [7:0] rxb;
    logic [7:0] obyte;
    logic [1:0] place;
    logic [1:0] insel;
    logic [2:0] bsel;
    logic din;
    logic lvl;
    logic hit;
    logic drv0;
    logic drv1;
    logic gen;
    rec = '0;
    nrec = '0;
    div = '0;
    cnt_n = '0;
    rxb = '0;
    obyte = '0;
    place = '0;
    insel = '0;
    bsel = '0;
    din = 1'b0;
    lvl = 1'b0;
    hit = 1'b0;
    drv0 = 1'b0;
    drv1 = 1'b0;
    gen = 1'b0;
    d = q;
    rise = '0;
    fall = '0;
    out_word_ready = '0;
    // Three-stage synchronisers; a change counts when stages two and three agree.
    d.s1 = {word_select_pin_in[4], word_select_pin_in[0], serial_data_pin_in,
            bit_clock_second_in, bit_clock_first_in, audio_ref_clock};
    d.s2 = q.s1;
    d.s3 = q.s2;
    for (int i = 0; i < SYN_W; i++) begin
      d.filt[i] = (q.s2[i] == q.s3[i]) ? q.s3[i] : q.filt[i];
    end
    aclk_rise = d.filt[SYN_ACLK] && !q.filt[SYN_ACLK];
    // Word for the fifo handshake lasts one cycle.
    for (int c = 0; c < NUM_CIRC; c++) begin
      if (q.in_val[c]) begin
        d.in_val[c] = 1'b0;
        if (!fifo_ready[c]) begin
          d.overrun[c] = 1'b1;
        end
      end
    end
    // List records are loaded by the host at any time.
    if (list_wr_en) begin
      d.time_slot_list[list_wr_circuit][list_wr_index] = list_wr_data;
    end
    for (int c = 0; c < NUM_CIRC; c++) begin
      rec = q.time_slot_list[c][q.slot[c][3:0]];
      nrec = rec[REC_LAST] ? q.time_slot_list[c][0] : q.time_slot_list[c][q.slot[c][3:0] + 4'h1];
      // Bit clock events, generated from the reference clock or taken from the pin.
      if (bit_clock_master[c]) begin
        div = DIV_TABLE[clock_div_sel[c]];
        if (aclk_rise) begin
          cnt_n = (q.div_cnt[c] >= div - 10'h001) ? '0 : q.div_cnt[c] + 10'h001;
          d.div_cnt[c] = cnt_n;
          if (cnt_n == '0) begin
            d.bclk[c] = 1'b1;
            rise[c] = 1'b1;
          end else if (cnt_n == (div >> 1)) begin
            d.bclk[c] = 1'b0;
            fall[c] = 1'b1;
          end
        end
      end else begin
        d.div_cnt[c] = '0;
        d.bclk[c] = 1'b0;
        rise[c] = d.filt[SYN_BCLK + c] && !q.filt[SYN_BCLK + c];
        fall[c] = !d.filt[SYN_BCLK + c] && q.filt[SYN_BCLK + c];
      end
      if (!circuit_enable[c]) begin
        // Idle circuit: bit and slot counters, pointers and flags return home, host may write feedback bytes.
        d.bitc[c] = FIRST_BIT;
        d.slot[c] = '0;
        d.in_ptr[c] = '0;
        d.fb_ptr[c] = '0;
        d.tx_act[c] = 1'b0;
        d.tx_bit[c] = 1'b0;
        d.ws[c] = '0;
        d.sync_lvl[c] = 1'b0;
        d.overrun[c] = 1'b0;
        if (fb_wr_en && (fb_wr_circuit == 1'(c))) begin
          d.fb[c] = fb_wr_data;
        end
      end else begin
        // Rising edge: sample data, follow the external sync, close the slot.
        if (rise[c]) begin
          insel = rec[REC_INSEL_LO +: 2];
          if (insel == 2'h0) begin
            din = q.filt[SYN_SD + 4 * c];
          end else begin
            din = q.filt[SYN_SD + int'(insel)];
          end
          lvl = q.filt[SYN_WS + c];
          d.sync_lvl[c] = lvl;
          hit = ext_sync_mode[c] && lvl && !q.sync_lvl[c];
          rxb = {q.rx[c][6:0], din};
          d.rx[c] = rxb;
          if (hit && !ext_sync_early[c]) begin
            d.bitc[c] = FIRST_BIT + 3'h1;
            d.slot[c] = '0;
            d.fb_ptr[c] = '0;
          end else if (hit) begin
            d.bitc[c] = FIRST_BIT;
            d.slot[c] = '0;
            d.fb_ptr[c] = '0;
          end else if (q.bitc[c] == LAST_BIT) begin
            d.bitc[c] = FIRST_BIT;
            if (rec[REC_STORE_LO +: 2] == STORE_DWORD ||
                rec[REC_STORE_LO +: 2] == STORE_BOTH) begin
              place = little_endian[c] ? q.in_ptr[c] : LAST_PLACE - q.in_ptr[c];
              d.in_buf[c][{place, 3'h0} +: 8] = rxb;
              d.in_ptr[c] = q.in_ptr[c] + 2'h1;
              if (q.in_ptr[c] == LAST_PLACE) begin
                d.in_word[c] = d.in_buf[c];
                d.in_val[c] = 1'b1;
              end
            end
            if (rec[REC_STORE_LO +: 2] == STORE_FB ||
                rec[REC_STORE_LO +: 2] == STORE_BOTH) begin
              d.fb[c][{q.fb_ptr[c], 3'h0} +: 8] = rxb;
              d.fb_ptr[c] = q.fb_ptr[c] + 2'h1;
            end
            if (rec[REC_LAST] || q.slot[c] == LAST_SLOT) begin
              d.slot[c] = '0;
              d.fb_ptr[c] = '0;
            end else begin
              d.slot[c] = q.slot[c] + 5'h01;
            end
          end else begin
            d.bitc[c] = q.bitc[c] + 3'h1;
          end
        end
        // Falling edge: shift out data and move the word selects.
        if (fall[c]) begin
          if (q.bitc[c] == FIRST_BIT) begin
            if (rec[REC_LOAD] && out_word_valid[c]) begin
              d.out_buf[c] = out_word_data[c];
              out_word_ready[c] = 1'b1;
            end
            bsel = rec[REC_BSEL_LO +: 3];
            if (bsel[2]) begin
              obyte = q.fb[c][{bsel[1:0], 3'h0} +: 8];
            end else begin
              obyte = d.out_buf[c][{bsel[1:0], 3'h0} +: 8];
            end
            d.tx_bit[c] = obyte[7];
            d.tx[c] = {obyte[6:0], 1'b0};
            d.tx_act[c] = rec[REC_OUT_EN];
            d.tx_pin[c] = rec[REC_PIN_LO +: 3];
            if (!ws_out_early[c]) begin
              d.ws[c] = rec[REC_WS_LO +: 5];
            end
          end else begin
            d.tx_bit[c] = q.tx[c][7];
            d.tx[c] = {q.tx[c][6:0], 1'b0};
          end
          if (ws_out_early[c] && q.bitc[c] == LAST_BIT) begin
            d.ws[c] = nrec[REC_WS_LO +: 5];
          end
        end
      end
    end
    // Data pins: end pins are tied to one circuit, shared pins prefer the first.
    for (int p = 0; p < NUM_PINS; p++) begin
      drv0 = circuit_enable[0] && d.tx_act[0] && d.tx_pin[0] == 3'(p) && p != 4;
      drv1 = circuit_enable[1] && d.tx_act[1] && d.tx_pin[1] == 3'(p) && p != 0 && !drv0;
      d.sd_out[p] = drv0 ? d.tx_bit[0] : (drv1 && d.tx_bit[1]);
      d.sd_oe_n[p] = !(drv0 || drv1);
    end
    // Word select pins: each chooses its generator; end pins drive only when asked.
    for (int p = 0; p < NUM_PINS; p++) begin
      gen = ws_gen_sel[p];
      d.ws_out[p] = d.ws[gen][p];
      if (p == 0 || p == 4) begin
        d.ws_oe_n[p] = !(circuit_enable[gen] && ws_pin_drive[p]);
      end else begin
        d.ws_oe_n[p] = !circuit_enable[gen];
      end
    end
  end

  // ----------------------------------------
  // State register.
  // ----------------------------------------
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      q <= '0;
      q.sd_oe_n <= '1;
      q.ws_oe_n <= '1;
    end else if (clk_en) begin
      q <= d;
    end
  end

  // ----------------------------------------
  // Input FIFOs for collected dwords.
  // ----------------------------------------
  for (genvar c = 0; c < NUM_CIRC; c++) begin : g_fifo
    tsa_fifo #(
      .WIDTH(32),
      .DEPTH(IN_FIFO_DEPTH)
    ) u_fifo (
      .clk(clk),
      .reset(reset),
      .clk_en(clk_en),
      .in_valid(q.in_val[c]),
      .in_ready(fifo_ready[c]),
      .in_data(q.in_word[c]),
      .out_valid(in_word_valid[c]),
      .out_ready(in_word_ready[c]),
      .out_data(in_word_data[c])
    );
  end

  // Pin and status outputs straight from the state register; bit clock enables are decoded from the inputs.
  assign bit_clock_first_out = q.bclk[0];
  assign bit_clock_first_oe_n = !(circuit_enable[0] && bit_clock_master[0]);
  assign bit_clock_second_out = q.bclk[1];
  assign bit_clock_second_oe_n = !(circuit_enable[1] && bit_clock_master[1]);
  assign serial_data_pin_out = q.sd_out;
  assign serial_data_pin_oe_n = q.sd_oe_n;
  assign word_select_pin_out = q.ws_out;
  assign word_select_pin_oe_n = q.ws_oe_n;
  assign fb_rd_data = q.fb;
  assign slot_count = q.slot;
  assign in_overrun = q.overrun;

endmodule

`default_nettype wire

// >>> tsa_port_chk.sv
`timescale 1ns/1ns
`default_nettype none

module tsa_port_chk
  import tsa_pkg::*;
(
  input wire logic clk,
  input wire logic reset,
  input wire logic clk_en,
  input wire logic [1:0] circuit_enable,
  input wire logic [1:0] bit_clock_master,
  input wire logic [4:0] ws_gen_sel,
  input wire logic [4:0] ws_pin_drive,
  input wire logic [4:0] serial_data_pin_oe_n,
  input wire logic [4:0] word_select_pin_oe_n,
  input wire logic bit_clock_first_oe_n,
  input wire logic [1:0][4:0] slot_count
);
  // ------------------------------------------------------------
  // Pin direction and slot timing checks
  // ------------------------------------------------------------
  // All checks share the system clock and its reset.
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  AST_BOTH_OFF: assert property (clk_en && circuit_enable == 2'h0 |=>
    &serial_data_pin_oe_n && &word_select_pin_oe_n[3:1]) else $error("pin driven while idle");
  AST_PIN4_OWN: assert property (clk_en && !circuit_enable[1] |=> serial_data_pin_oe_n[4])
    else $error("data pin four driven without second circuit");
  AST_PIN0_OWN: assert property (clk_en && !circuit_enable[0] |=> serial_data_pin_oe_n[0])
    else $error("data pin zero driven without first circuit");
  AST_WS0_IN: assert property (clk_en && !ws_pin_drive[0] |=> word_select_pin_oe_n[0])
    else $error("word select zero driven while used as sync input");
  AST_WS4_IN: assert property (clk_en && !ws_pin_drive[4] |=> word_select_pin_oe_n[4])
    else $error("word select four driven while used as sync input");
  AST_WS1_GEN: assert property (clk_en && circuit_enable[ws_gen_sel[1]] |=>
    !word_select_pin_oe_n[1]) else $error("word select one not driven by its generator");
  AST_BCLK_DIR: assert property (bit_clock_first_oe_n ==
    !(circuit_enable[0] && bit_clock_master[0])) else $error("bit clock direction wrong");
  AST_SLOT_STEP: assert property (clk_en && !$stable(slot_count[0]) |->
    slot_count[0] == $past(slot_count[0]) + 5'h01 || slot_count[0] == 5'h00)
    else $error("slot counter jumped");
  AST_SLOT_HOLD: assert property ($changed(slot_count[0]) && circuit_enable[0] |=>
    ($stable(slot_count[0]) || !circuit_enable[0]) [*8]) else $error("slot shorter than a byte");
endmodule

bind tsa_port tsa_port_chk u_chk (.*);

`default_nettype wire

// >>> tsa_codec.sv
`timescale 1ns/1ns
`default_nettype none

module tsa_codec (
  input wire logic run,
  input wire logic [31:0] tx,
  input wire logic sd_rx,
  input wire logic ws_rx,
  output logic aref,
  output logic bclk,
  output logic ws,
  output logic sd,
  output logic [8:0] rx,
  output logic stb
);
  // ------------------------------------------------------------
  // Framing master codec
  // ------------------------------------------------------------
  int n;
  logic [7:0] sh;
  logic wsr;

  // Board reference clock at its ceiling rate.
  initial begin
    aref = 1'b0;
    forever #20 aref = ~aref;
  end

  // Bit clock idles high while run is low; data and sync change on the fall.
  initial begin
    bclk = 1'b1;
    ws = 1'b0;
    sd = 1'b0;
    stb = 1'b0;
    rx = 9'h000;
    sh = 8'h00;
    wsr = 1'b0;
    n = 0;
    forever begin
      #40;
      if (run) begin
        bclk = 1'b0;
        stb = 1'b0;
        ws = n < 8;
        sd = tx[31 - n];
        #40;
        bclk = 1'b1;
        sh = {sh[6:0], sd_rx};
        if (n % 8 == 0) wsr = ws_rx;
        rx = {wsr, sh};
        stb = n % 8 == 7;
        n = (n + 1) % 32;
      end else begin
        n = 0;
        sd = ~sd;
      end
    end
  end
endmodule

`default_nettype wire

// >>> tsa_port_test.sv
`timescale 1ns/1ns
`default_nettype none
`define CHK(nm, e, g) begin ev = 64'(e); n_tests++; if ((g) !== ev) begin n_mismatch++; \
  $display("BAD %s exp %h got %h", nm, ev, g); end end

module tsa_port_test
  import tsa_pkg::*;
;
  // ------------------------------------------------------------
  // Bench signals
  // ------------------------------------------------------------
  localparam logic [7:0] ST = 8'hB7;
  logic clk, reset, clk_en, audio_ref_clock, bit_clock_first_in, bit_clock_second_in;
  logic bit_clock_first_out, bit_clock_first_oe_n, bit_clock_second_out, bit_clock_second_oe_n;
  logic [4:0] serial_data_pin_in, serial_data_pin_out, serial_data_pin_oe_n;
  logic [4:0] word_select_pin_in, word_select_pin_out, word_select_pin_oe_n;
  logic [1:0] circuit_enable, bit_clock_master, ext_sync_mode, ext_sync_early, ws_out_early;
  logic [1:0] little_endian, out_word_valid, out_word_ready, in_word_valid, in_word_ready;
  logic [1:0] in_overrun;
  logic [1:0][3:0] clock_div_sel;
  logic [4:0] ws_gen_sel, ws_pin_drive;
  logic list_wr_en, list_wr_circuit, fb_wr_en, fb_wr_circuit, run, c_bclk, c_ws, c_sd, c_stb;
  logic [3:0] list_wr_index;
  logic [31:0] list_wr_data, fb_wr_data, tw;
  logic [1:0][31:0] fb_rd_data, out_word_data, in_word_data;
  logic [1:0][4:0] slot_count;
  logic [8:0] c_rx;
  logic [63:0] ev;
  logic tg = 1'b0;
  logic [8:0] qs[$];
  logic [31:0] qw[$];
  int seed, nrx, n_tests, n_mismatch;

  tsa_port uut (.*);

  tsa_codec u_codec (.run(run), .tx(tw), .sd_rx(serial_data_pin_in[1]),
    .ws_rx(word_select_pin_in[1]), .aref(audio_ref_clock), .bclk(c_bclk), .ws(c_ws),
    .sd(c_sd), .rx(c_rx), .stb(c_stb));

  // Wire levels: an undriven line shows the codec's signal (data pin 2, word select 0, first bit clock) or a pattern that changes every cycle.
  assign serial_data_pin_in = serial_data_pin_out & ~serial_data_pin_oe_n
    | serial_data_pin_oe_n & {tg, tg, c_sd, tg, tg};
  assign word_select_pin_in = word_select_pin_out & ~word_select_pin_oe_n
    | word_select_pin_oe_n & {tg, tg, tg, tg, c_ws};
  assign bit_clock_first_in = bit_clock_first_oe_n ? c_bclk : bit_clock_first_out;
  assign bit_clock_second_in = bit_clock_second_oe_n ? tg : bit_clock_second_out;

  // System clock and the idle-line pattern.
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  always @(posedge clk) tg <= ~tg;

  // Serial bytes and word select caught by the codec.
  always @(posedge c_stb) begin
    nrx++;
    `CHK("serial", qs.pop_front(), c_rx)
  end

  // Collected dwords leaving the input FIFO, looked at mid-cycle while they stand.
  always @(negedge clk) begin
    if (in_word_valid[0] === 1'b1) `CHK("in_word", qw.pop_front(), in_word_data[0])
  end

  // ------------------------------------------------------------
  // Tasks
  // ------------------------------------------------------------
  task automatic close_out;
    begin
      $display("checks %0d mismatches %0d", n_tests, n_mismatch);
      if (n_mismatch == 0 && n_tests > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
    end
  endtask

  // Reset and check the idle state.
  task automatic rst;
    begin
      reset = 1'b1;
      circuit_enable = 2'h0;
      ws_pin_drive = 5'h00;
      repeat (3) @(negedge clk);
      reset = 1'b0;
      @(negedge clk);
      `CHK("sd_oe_n", 5'h1F, serial_data_pin_oe_n)
      `CHK("ws_oe_n", 5'h1F, word_select_pin_oe_n)
      `CHK("slot", 10'h000, slot_count)
      `CHK("fb", 64'h0, fb_rd_data)
      `CHK("in_valid", 2'h0, in_word_valid)
      $display("test reset done");
    end
  endtask

  // Four-slot frames: slot 1 skips feedback, slot 3 skips the dword.
  task automatic run_frames(input logic le);
    logic [31:0] fi, ex, lf;
    logic [7:0] bj;
    int i;
    begin
      fi = $random(seed);
      tw = $random(seed);
      lf = {fi[31:24], tw[7:0], tw[15:8], tw[31:24]};
      nrx = 0;
      little_endian = {1'b0, le};
      clock_div_sel = 8'($random(seed));
      ws_gen_sel = 5'($random(seed)) & 5'h1D;
      ws_pin_drive = 5'($random(seed)) & 5'h10;
      fb_wr_en = 1'b1;
      fb_wr_data = fi;
      @(negedge clk);
      fb_wr_en = 1'b0;
      list_wr_en = 1'b1;
      for (i = 0; i < 4; i++) begin
        list_wr_index = 4'(i);
        list_wr_data = {(i == 0) ? 5'h02 : 5'h00, ST[2*i +: 2], 3'h4 | 3'(i), 6'h26, 15'h0000,
          i == 3};
        @(negedge clk);
      end
      list_wr_en = 1'b0;
      circuit_enable = 2'h1;
      for (i = 0; i < 12; i++) begin
        bj = tw[31 - 8 * (i % 3) -: 8];
        ex = le ? {bj, ex[31:8]} : {ex[23:0], bj};
        if (i % 4 == 3) qw.push_back(ex);
      end
      for (i = 0; i < 16; i++) begin
        qs.push_back({i % 4 == 0, (i < 4) ? fi[8*(i%4) +: 8] : lf[8*(i%4) +: 8]});
      end
      @(negedge clk);
      fb_wr_en = 1'b1;
      fb_wr_data = ~fi;
      @(negedge clk);
      fb_wr_en = 1'b0;
      run = 1'b1;
      for (i = 0; i < 40000 && nrx < 16; i++) @(negedge clk);
      if (nrx < 16) begin
        n_mismatch++;
        close_out();
      end
      run = 1'b0;
      repeat (200) @(negedge clk);
      `CHK("overrun", 2'h0, in_overrun)
      circuit_enable = 2'h0;
      repeat (3) @(negedge clk);
      `CHK("fb_rd", lf, fb_rd_data[0])
      `CHK("dwords_left", 0, qw.size())
      `CHK("bytes_left", 0, qs.size())
      $display("test frames le=%0d done", le);
    end
  endtask

  // Master bit clock: rise-to-rise spacing in system clocks for two divider stages.
  task automatic master_clock;
    int i, k, t0, nr;
    logic lb;
    begin
      bit_clock_master = 2'h1;
      circuit_enable = 2'h1;
      for (k = 0; k < 2; k++) begin
        clock_div_sel = {4'h0, (k == 1) ? 4'hE : 4'h3};
        nr = 0;
        t0 = 0;
        lb = 1'b1;
        for (i = 0; i < 20000 && nr < 3; i++) begin
          @(negedge clk);
          if (bit_clock_first_out && !lb) begin
            nr++;
            if (nr == 2) t0 = i;
          end
          lb = bit_clock_first_out;
        end
        if (nr < 3) begin
          n_mismatch++;
          close_out();
        end
        `CHK("bclk_period", (k == 1) ? 3840 : 80, i - 1 - t0)
      end
      bit_clock_master = 2'h0;
      circuit_enable = 2'h0;
      $display("test master clock done");
    end
  endtask

  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial begin
    seed = 25062;
    clk_en = 1'b1;
    run = 1'b0;
    bit_clock_master = 2'h0;
    ext_sync_mode = 2'h3;
    ext_sync_early = 2'h0;
    ws_out_early = 2'h0;
    little_endian = 2'h0;
    out_word_valid = 2'h0;
    out_word_data = 64'h0;
    in_word_ready = 2'h3;
    clock_div_sel = 8'h00;
    ws_gen_sel = 5'h00;
    list_wr_en = 1'b0;
    list_wr_circuit = 1'b0;
    list_wr_index = 4'h0;
    list_wr_data = 32'h0;
    fb_wr_en = 1'b0;
    fb_wr_circuit = 1'b0;
    fb_wr_data = 32'h0;
    tw = 32'h0;
    rst();
    run_frames(1'b0);
    rst();
    run_frames(1'b1);
    master_clock();
    close_out();
  end
endmodule

`default_nettype wire
